// File: logic/t1rx_top.sv
// T1 receive status reporting and line interface: control stream, phase, signalling, AMI pins.
// Assumes the framer supplies sync state, frame alignment, CRC errors and signalling on clk.
//
// Behaviour
// - Blue alarm sets on two all-ones frames while out of frame; zero in 250us clears.
// - Wrap bit toggles when phase reading passes 31/7 upward or 0/0 downward.
// - Status-two bit 5 mirrors external scan pin, sampled once per bus frame.
// - Violation tally bits toggle every 128 and every 64 counted violations.
// - Three-bit checksum error tally wraps at terminal count; meaningful in ESF only.
// - Status-two word goes out in control stream channel 31.
// - Phase word in channel 3: bus channel and bit from frame pulse to reference rise.
// - Per-channel status words carry zeros in 7-4 and A,B,C,D in 3-0.
// - With debounce enabled, signalling changes are reported after 6 to 9 ms stability.
// - Signalling stored per channel and repeated every bus frame with newest values.
// - In ESF all four bits valid; reporting frozen while synchronization is lost.
// - In D3/D4 only A,B valid; frozen while terminal frame sync is lost.
// - Recovered clock divided by 193, frame aligned, output as 8 kHz reference.
// - Two unipolar transmit outputs carry positive and negative AMI pulses.
// - Front-end gives split-phase pair and their NAND; NRZ holds pair high.
// - All three receive inputs sampled on falling edge of recovered clock.
`timescale 1ns/1ps
`default_nettype none
module t1rx_top
   import t1rx_pkg::*;
#(
   parameter int BLUE_WINDOW_CYCLES = BLUE_WINDOW_CYC,
   parameter int DEBOUNCE_TICK_CYCLES = DEBOUNCE_TICK_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // System bus pins
   input wire logic bus_clock_in,
   input wire logic frame_pulse_n_in,
   output logic control_stream_out,
   // Line pins
   input wire logic transmit_clock_in,
   input wire logic recovered_clock_in,
   input wire logic rx_positive_pulse_n,
   input wire logic rx_negative_pulse_n,
   input wire logic rx_combined_in,
   output logic tx_positive_pulse,
   output logic tx_negative_pulse,
   output logic frame_reference_out,
   // Scan point
   input wire logic external_scan_input,
   // Framer side
   input wire t1rx_framer_s framer,
   input wire t1rx_sig_update_s sig_update,
   input wire logic tx_data_in,
   output logic rx_data_out,
   output logic rx_bit_strobe
);

   localparam int DBW = $clog2(DEBOUNCE_TICK_CYCLES + 1);
   localparam int BWW = $clog2(BLUE_WINDOW_CYCLES + 1);

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [7:0] pins_sync;
   logic bus_clk_s;
   logic frame_n_s;
   logic tx_clk_s;
   logic rec_clk_s;
   logic rx_pos_n_s;
   logic rx_neg_n_s;
   logic rx_comb_s;
   logic ext_s;
   logic bus_clk_prev_q;
   logic tx_clk_prev_q;
   logic rec_clk_prev_q;
   logic bus_rise;
   logic tx_rise;
   logic rec_fall;

   t1rx_sync #(
      .WIDTH(8)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in({bus_clock_in, frame_pulse_n_in, transmit_clock_in, recovered_clock_in,
                 rx_positive_pulse_n, rx_negative_pulse_n, rx_combined_in, external_scan_input}),
      .sync_out(pins_sync)
   );

   assign {bus_clk_s, frame_n_s, tx_clk_s, rec_clk_s, rx_pos_n_s, rx_neg_n_s, rx_comb_s, ext_s} = pins_sync;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bus_clk_prev_q <= 1'b0;
         tx_clk_prev_q <= 1'b0;
         rec_clk_prev_q <= 1'b0;
      end
      else
      begin
         bus_clk_prev_q <= bus_clk_s;
         tx_clk_prev_q <= tx_clk_s;
         rec_clk_prev_q <= rec_clk_s;
      end
   end

   assign bus_rise = bus_clk_s & ~bus_clk_prev_q;
   assign tx_rise = tx_clk_s & ~tx_clk_prev_q;
   assign rec_fall = ~rec_clk_s & rec_clk_prev_q;

   // ----------------------------------------------------------------
   // Receive sampling and violation counting
   // ----------------------------------------------------------------
   logic mark_pos;
   logic mark_neg;
   logic last_neg_q;
   logic violation;
   logic [7:0] viol_cnt_q;

   // Split-phase inputs are active low; an NRZ feed holds both high and never counts
   assign mark_pos = ~rx_pos_n_s;
   assign mark_neg = ~rx_neg_n_s;
   assign violation = rec_fall & ((mark_pos & ~mark_neg & ~last_neg_q) | (mark_neg & ~mark_pos & last_neg_q));

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         last_neg_q <= 1'b0;
         viol_cnt_q <= VIOL_RESET;
         rx_data_out <= 1'b0;
         rx_bit_strobe <= 1'b0;
      end
      else
      begin
         rx_bit_strobe <= rec_fall;
         if (rec_fall)
         begin
            rx_data_out <= rx_comb_s;
            if (mark_pos ^ mark_neg)
            begin
               last_neg_q <= mark_neg;
            end
         end
         if (violation)
         begin
            viol_cnt_q <= viol_cnt_q + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Frame reference divider
   // ----------------------------------------------------------------
   logic [7:0] div_q;
   logic [7:0] div_d;
   logic align_pend_q;
   logic ref_rise;

   always_comb
   begin
      if (align_pend_q || framer.frame_align || div_q == DS1_LAST_BIT)
      begin
         div_d = 8'h00;
      end
      else
      begin
         div_d = div_q + 8'h01;
      end
   end

   assign ref_rise = rec_fall & (div_d == 8'h00);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         div_q <= 8'h00;
         align_pend_q <= 1'b0;
         frame_reference_out <= 1'b0;
      end
      else
      begin
         // Alignment is held until the next line bit so it cannot fall between edges
         if (rec_fall)
         begin
            div_q <= div_d;
            align_pend_q <= 1'b0;
            frame_reference_out <= (div_d < FRAME_REF_HIGH);
         end
         else if (framer.frame_align)
         begin
            align_pend_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Blue alarm
   // ----------------------------------------------------------------
   logic frame_ones_q;
   logic [1:0] ones_frames_q;
   logic [BWW-1:0] win_cnt_q;
   logic zero_seen_q;
   logic win_end;
   logic blue_set;
   logic blue_clr;
   logic blue_q;

   assign win_end = (win_cnt_q == BWW'(BLUE_WINDOW_CYCLES - 1));
   assign blue_set = (ones_frames_q == 2'(BLUE_FRAMES)) & framer.sync_lost;
   assign blue_clr = win_end & (zero_seen_q | (rec_fall & ~rx_comb_s));

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         frame_ones_q <= 1'b1;
         ones_frames_q <= 2'h0;
         win_cnt_q <= '0;
         zero_seen_q <= 1'b0;
         blue_q <= 1'b0;
      end
      else
      begin
         if (rec_fall)
         begin
            if (div_d == 8'h00)
            begin
               frame_ones_q <= 1'b1;
               if (!(frame_ones_q & rx_comb_s))
               begin
                  ones_frames_q <= 2'h0;
               end
               else if (ones_frames_q != 2'(BLUE_FRAMES))
               begin
                  ones_frames_q <= ones_frames_q + 2'h1;
               end
            end
            else
            begin
               frame_ones_q <= frame_ones_q & rx_comb_s;
            end
         end
         win_cnt_q <= win_end ? '0 : win_cnt_q + BWW'(1);
         zero_seen_q <= ~win_end & (zero_seen_q | (rec_fall & ~rx_comb_s));
         // A fresh set outranks the window clear in the same cycle
         blue_q <= blue_set | (blue_q & ~blue_clr);
      end
   end

   // ----------------------------------------------------------------
   // Bus timing, phase reading and scan point
   // ----------------------------------------------------------------
   logic [7:0] bus_bit_q;
   logic [7:0] bus_bit_d;
   logic [7:0] phase_q;
   logic wrap_q;
   logic ext_q;
   logic [2:0] crc_cnt_q;

   assign bus_bit_d = frame_n_s ? bus_bit_q + 8'h01 : 8'h00;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bus_bit_q <= 8'h00;
         ext_q <= 1'b0;
      end
      else if (bus_rise)
      begin
         bus_bit_q <= bus_bit_d;
         if (!frame_n_s)
         begin
            ext_q <= ext_s;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         phase_q <= PHASE_RESET;
         wrap_q <= 1'b0;
      end
      else if (ref_rise)
      begin
         phase_q <= bus_bit_q;
         // Readings jump by far less than half a frame, so a big step means a wrap
         if ((phase_q >= PHASE_WRAP_HI && bus_bit_q < PHASE_WRAP_LO) ||
             (phase_q < PHASE_WRAP_LO && bus_bit_q >= PHASE_WRAP_HI))
         begin
            wrap_q <= ~wrap_q;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         crc_cnt_q <= CRC_RESET;
      end
      else if (framer.crc_error && framer.esf_mode)
      begin
         crc_cnt_q <= crc_cnt_q + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // Signalling storage, freeze and debounce
   // ----------------------------------------------------------------
   logic freeze;
   logic [3:0] sig_value;
   logic [DBW-1:0] db_cnt_q;
   logic db_tick;
   logic [3:0] reported_q [SIG_CHANNELS];

   assign freeze = framer.esf_mode ? framer.sync_lost : framer.terminal_sync_lost;
   assign sig_value = framer.esf_mode ? sig_update.abcd : {sig_update.abcd[3:2], 2'b00};
   assign db_tick = (db_cnt_q == DBW'(DEBOUNCE_TICK_CYCLES - 1));

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         db_cnt_q <= '0;
      end
      else
      begin
         db_cnt_q <= db_tick ? '0 : db_cnt_q + DBW'(1);
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < SIG_CHANNELS; ch++)
      begin : g_sig
         logic [3:0] cand_q;
         logic [1:0] stable_q;
         logic hit;

         assign hit = sig_update.valid & (sig_update.channel == 5'(ch)) & ~freeze;

         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               reported_q[ch] <= SIG_RESET;
               cand_q <= SIG_RESET;
               stable_q <= 2'h0;
            end
            else if (!framer.debounce_enable)
            begin
               cand_q <= hit ? sig_value : reported_q[ch];
               stable_q <= 2'h0;
               if (hit)
               begin
                  reported_q[ch] <= sig_value;
               end
            end
            else if (hit && sig_value != cand_q)
            begin
               cand_q <= sig_value;
               stable_q <= 2'h0;
            end
            else if (db_tick && !freeze && cand_q != reported_q[ch])
            begin
               // Three tick boundaries after a change span 6 to 9 ms
               if (stable_q == 2'(DEBOUNCE_TICKS - 1))
               begin
                  reported_q[ch] <= cand_q;
                  stable_q <= 2'h0;
               end
               else
               begin
                  stable_q <= stable_q + 2'h1;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Control stream serialiser
   // ----------------------------------------------------------------
   logic [7:0] status_two;
   logic [7:0] slot_word;
   logic [4:0] slot_chan;
   logic [4:0] sig_idx;

   always_comb
   begin
      status_two = 8'h00;
      status_two[MS2_BLUE_BIT] = blue_q;
      status_two[MS2_WRAP_BIT] = wrap_q;
      status_two[MS2_EXT_BIT] = ext_q;
      status_two[MS2_VIOL_HI_BIT] = viol_cnt_q[VIOL_HI_SRC];
      status_two[MS2_VIOL_LO_BIT] = viol_cnt_q[VIOL_LO_SRC];
      status_two[MS2_CRC_LSB +: 3] = crc_cnt_q;
   end

   assign slot_chan = bus_bit_d[7:3];

   always_comb
   begin
      sig_idx = 5'h00;
      slot_word = 8'h00;
      if (slot_chan == PHASE_CHANNEL)
      begin
         slot_word = phase_q;
      end
      else if (slot_chan == STATUS2_CHANNEL)
      begin
         slot_word = status_two;
      end
      else if (slot_chan >= SIG_LOW_FIRST && slot_chan <= SIG_LOW_LAST)
      begin
         sig_idx = slot_chan - SIG_LOW_FIRST;
         slot_word = {SIG_UNUSED_HI, reported_q[sig_idx]};
      end
      else if (slot_chan >= SIG_HIGH_FIRST && slot_chan <= SIG_HIGH_LAST)
      begin
         sig_idx = slot_chan - SIG_HIGH_FIRST + (SIG_LOW_LAST - SIG_LOW_FIRST + 5'h01);
         slot_word = {SIG_UNUSED_HI, reported_q[sig_idx]};
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         control_stream_out <= 1'b0;
      end
      else if (bus_rise)
      begin
         control_stream_out <= slot_word[~bus_bit_d[2:0]];
      end
   end

   // ----------------------------------------------------------------
   // AMI transmit encoder
   // ----------------------------------------------------------------
   logic next_neg_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tx_positive_pulse <= 1'b0;
         tx_negative_pulse <= 1'b0;
         next_neg_q <= 1'b0;
      end
      else if (tx_rise)
      begin
         tx_positive_pulse <= tx_data_in & ~next_neg_q;
         tx_negative_pulse <= tx_data_in & next_neg_q;
         if (tx_data_in)
         begin
            next_neg_q <= ~next_neg_q;
         end
      end
   end

endmodule // t1rx_top
`default_nettype wire

// File: logic/t1rx_pkg.sv
// Constants, field layouts and carrier types for the T1 receive status and line interface.
// Assumes a single 200 MHz system clock; every line and bus clock arrives as a pin and is sampled.
package t1rx_pkg;

   // ----------------------------------------------------------------
   // System clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_HZ = 200_000_000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int BLUE_WINDOW_US = 250;
   localparam int BLUE_WINDOW_CYC = BLUE_WINDOW_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int DEBOUNCE_MIN_MS = 6;
   localparam int DEBOUNCE_MAX_MS = 9;
   localparam int DEBOUNCE_TICK_CYC = (DEBOUNCE_MAX_MS - DEBOUNCE_MIN_MS) * (CLK_FREQ_HZ / 1000);
   localparam int DEBOUNCE_TICKS = DEBOUNCE_MIN_MS / (DEBOUNCE_MAX_MS - DEBOUNCE_MIN_MS) + 1;

   // ----------------------------------------------------------------
   // Frame geometry
   // ----------------------------------------------------------------
   localparam logic [7:0] DS1_LAST_BIT = 8'hC0;
   localparam logic [7:0] FRAME_REF_HIGH = 8'h60;
   localparam int BLUE_FRAMES = 2;
   localparam int SIG_CHANNELS = 24;
   localparam logic [4:0] PHASE_CHANNEL = 5'h03;
   localparam logic [4:0] STATUS2_CHANNEL = 5'h1F;
   localparam logic [4:0] SIG_LOW_FIRST = 5'h04;
   localparam logic [4:0] SIG_LOW_LAST = 5'h0E;
   localparam logic [4:0] SIG_HIGH_FIRST = 5'h10;
   localparam logic [4:0] SIG_HIGH_LAST = 5'h1C;

   // ----------------------------------------------------------------
   // Status word fields and reset values
   // ----------------------------------------------------------------
   localparam int MS2_BLUE_BIT = 7;
   localparam int MS2_WRAP_BIT = 6;
   localparam int MS2_EXT_BIT = 5;
   localparam int MS2_VIOL_HI_BIT = 4;
   localparam int MS2_VIOL_LO_BIT = 3;
   localparam int MS2_CRC_LSB = 0;
   localparam int VIOL_HI_SRC = 7;
   localparam int VIOL_LO_SRC = 6;
   localparam logic [7:0] PHASE_WRAP_HI = 8'hC0;
   localparam logic [7:0] PHASE_WRAP_LO = 8'h40;
   localparam logic [7:0] PHASE_RESET = 8'h00;
   localparam logic [7:0] VIOL_RESET = 8'h00;
   localparam logic [2:0] CRC_RESET = 3'h0;
   localparam logic [3:0] SIG_RESET = 4'h0;
   localparam logic [3:0] SIG_UNUSED_HI = 4'h0;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [4:0] channel;
      logic [3:0] abcd;
   } t1rx_sig_update_s;

   typedef struct packed {
      logic esf_mode;
      logic sync_lost;
      logic terminal_sync_lost;
      logic frame_align;
      logic crc_error;
      logic debounce_enable;
   } t1rx_framer_s;

endpackage

// File: logic/t1rx_sync.sv
// Two flip-flop synchroniser bank for pins and foreign clocks.
// Assumes each bit is an independent level; no multi-bit coherence is given.
`timescale 1ns/1ps
`default_nettype none
module t1rx_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // t1rx_sync
`default_nettype wire

// File: sim/t1rx_monitor.sv
// Checker for the T1 status top: transmit pair, receive sampling, reference.
// Assumes far-side bits of 10 clk or more; bound below.
`timescale 1ns/1ps
`default_nettype none
module t1rx_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins in
   input wire logic bus_clock_in,
   input wire logic transmit_clock_in,
   input wire logic rx_combined_in,
   // Pins out
   input wire logic control_stream_out,
   input wire logic tx_positive_pulse,
   input wire logic tx_negative_pulse,
   input wire logic frame_reference_out,
   input wire logic rx_data_out,
   input wire logic rx_bit_strobe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic last_pos_q;
   logic [8:0] hi_q;
   logic [8:0] per_q;
   logic [1:0] rises_q;

   // ----------
   // Helpers
   // ----------
   always_ff @(posedge clk)
      if (rst)
         last_pos_q <= 1'b0;
      else if (tx_positive_pulse)
         last_pos_q <= 1'b1;
      else if (tx_negative_pulse)
         last_pos_q <= 1'b0;

   // Strobes stand in for the hidden divider; first period skipped
   always_ff @(posedge clk)
      if (rst)
      begin
         hi_q <= 9'h000;
         per_q <= 9'h000;
         rises_q <= 2'h0;
      end
      else if ($rose(frame_reference_out))
      begin
         hi_q <= 9'(rx_bit_strobe);
         per_q <= 9'(rx_bit_strobe);
         rises_q <= (rises_q == 2'h3) ? rises_q : rises_q + 2'h1;
      end
      else
      begin
         hi_q <= hi_q + 9'(rx_bit_strobe & frame_reference_out);
         per_q <= per_q + 9'(rx_bit_strobe);
      end

   // ----------
   // Assertions
   // ----------
   sequence s_tx_quiet;
      (!transmit_clock_in) [*6];
   endsequence
   sequence s_bus_quiet;
      (!bus_clock_in) [*6];
   endsequence

   a_tx_exclusive: assert property (!(tx_positive_pulse && tx_negative_pulse))
      else $error("Both transmit outputs high");
   a_pos_alternate: assert property ($rose(tx_positive_pulse) |-> !last_pos_q)
      else $error("Positive mark repeated");
   a_neg_alternate: assert property ($rose(tx_negative_pulse) |-> last_pos_q)
      else $error("Negative mark repeated");
   a_tx_clocked: assert property (s_tx_quiet |=> $stable(tx_positive_pulse) && $stable(tx_negative_pulse))
      else $error("Transmit moved unclocked");
   a_stream_clocked: assert property (s_bus_quiet |=> $stable(control_stream_out))
      else $error("Stream moved unclocked");
   a_reset_quiet: assert property ($fell(rst) |-> !(control_stream_out || tx_positive_pulse
      || tx_negative_pulse || frame_reference_out || rx_bit_strobe))
      else $error("Output active after reset");
   a_rx_sample: assert property (rx_bit_strobe |-> rx_data_out == rx_combined_in)
      else $error("Receive sample differs from line");
   a_strobe_gap: assert property (rx_bit_strobe |=> !rx_bit_strobe [*8])
      else $error("Receive strobe too close");
   a_ref_high: assert property ($fell(frame_reference_out) && rises_q >= 2'h2 |-> hi_q == 9'h060)
      else $error("Reference high time wrong");
   a_ref_period: assert property ($rose(frame_reference_out) && rises_q >= 2'h2 |-> per_q == 9'h0C1)
      else $error("Reference period not 193 bits");
endmodule // t1rx_monitor

bind t1rx_top t1rx_monitor u_mon (
   .clk(clk), .rst(rst), .bus_clock_in(bus_clock_in), .transmit_clock_in(transmit_clock_in),
   .rx_combined_in(rx_combined_in), .control_stream_out(control_stream_out),
   .tx_positive_pulse(tx_positive_pulse), .tx_negative_pulse(tx_negative_pulse),
   .frame_reference_out(frame_reference_out), .rx_data_out(rx_data_out), .rx_bit_strobe(rx_bit_strobe)
);
`default_nettype wire

// File: sim/t1rx_partner.sv
// Line front-end and system bus model.
// Assumes a 200 MHz clk; bus and line bits last 16 clk, transmit bits 4096/193 clk.
`timescale 1ns/1ps
`default_nettype none
module t1rx_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pattern: 0 AMI ones, 1 same-polarity ones, 2 zeros, 3 NRZ ones
   input wire logic [1:0] rx_mode,
   // System bus
   output logic bus_clock_in,
   output logic frame_pulse_n_in,
   input wire logic control_stream_out,
   output logic [255:0] frame_bits,
   output logic [15:0] frames,
   // Line
   output logic transmit_clock_in,
   output logic recovered_clock_in,
   output logic rx_positive_pulse_n,
   output logic rx_negative_pulse_n,
   output logic rx_combined_in
);
   logic [3:0] bc_q;
   logic [11:0] tc_q;
   logic [3:0] rc_q;
   logic [7:0] idx_q;
   logic [255:0] cap_q;
   logic pol_q;
   assign bus_clock_in = bc_q[3];
   assign transmit_clock_in = tc_q[11];
   assign recovered_clock_in = rc_q[3];

   // Stream bits taken at bus clock fall, clear of the update
   always_ff @(posedge clk)
      if (rst)
      begin
         bc_q <= 4'h0;
         idx_q <= 8'hFF;
         frame_pulse_n_in <= 1'b0;
         frames <= 16'h0000;
         cap_q <= 256'h0;
         frame_bits <= 256'h0;
      end
      else
      begin
         bc_q <= bc_q + 4'h1;
         if (bc_q == 4'h7)
            idx_q <= idx_q + 8'h01;
         if (bc_q == 4'hF)
         begin
            cap_q[8'hFF - idx_q] <= control_stream_out;
            frame_pulse_n_in <= (idx_q != 8'hFF);
            if (idx_q == 8'hFF)
            begin
               frame_bits <= {cap_q[255:1], control_stream_out};
               frames <= frames + 16'h0001;
            end
         end
      end

   always_ff @(posedge clk)
      if (rst)
      begin
         tc_q <= 12'h000;
         rc_q <= 4'hA;
         pol_q <= 1'b0;
         rx_positive_pulse_n <= 1'b1;
         rx_negative_pulse_n <= 1'b1;
         rx_combined_in <= 1'b0;
      end
      else
      begin
         tc_q <= tc_q + 12'h0C1;
         rc_q <= rc_q + 4'h1;
         if (rc_q == 4'h7)
         begin
            pol_q <= ~pol_q;
            rx_positive_pulse_n <= rx_mode[1] || (rx_mode == 2'h0 && pol_q);
            rx_negative_pulse_n <= rx_mode != 2'h0 || !pol_q;
            rx_combined_in <= rx_mode != 2'h2;
         end
      end
endmodule // t1rx_partner
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the T1 status top.
// Assumes the partner model and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
module tb
   import t1rx_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic external_scan_input = 1'b0;
   logic tx_data_in = 1'b0;
   logic [1:0] rx_mode = 2'h0;
   t1rx_framer_s framer = '0;
   t1rx_sig_update_s sig_update = '0;
   logic bus_clock_in, frame_pulse_n_in, control_stream_out, transmit_clock_in, recovered_clock_in;
   logic rx_positive_pulse_n, rx_negative_pulse_n, rx_combined_in, tx_positive_pulse, tx_negative_pulse;
   logic frame_reference_out, rx_data_out, rx_bit_strobe;
   logic [255:0] frame_bits;
   logic [15:0] frames;
   logic [7:0] w;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;

   // Short counts keep the run near 50k cycles
   t1rx_top #(.BLUE_WINDOW_CYCLES(200), .DEBOUNCE_TICK_CYCLES(2000)) dut (
      .clk, .rst, .bus_clock_in, .frame_pulse_n_in, .control_stream_out, .transmit_clock_in,
      .recovered_clock_in, .rx_positive_pulse_n, .rx_negative_pulse_n, .rx_combined_in,
      .tx_positive_pulse, .tx_negative_pulse, .frame_reference_out, .external_scan_input,
      .framer, .sig_update, .tx_data_in, .rx_data_out, .rx_bit_strobe);
   t1rx_partner u_far (
      .clk, .rst, .rx_mode, .bus_clock_in, .frame_pulse_n_in, .control_stream_out, .frame_bits,
      .frames, .transmit_clock_in, .recovered_clock_in, .rx_positive_pulse_n, .rx_negative_pulse_n,
      .rx_combined_in);

   always #2.5 clk = ~clk;

   // ----------
   // Shared tasks
   // ----------
   task automatic conclude();
      $display("Checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 70000)
      begin
         mismatches++;
         $display("BAD cycles expected below 70000 seen %0d", cycles);
         conclude();
      end
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wait_frames(input int n);
      logic [15:0] target;
      target = frames + n[15:0];
      while (frames !== target)
         tick(1);
   endtask

   task automatic get(input int ch);
      w = frame_bits[255 - 8 * ch -: 8];
   endtask

   task automatic send_sig(input logic [4:0] ch, input logic [3:0] v);
      tick(1);
      sig_update = {1'b1, ch, v};
      tick(1);
      sig_update = '0;
   endtask

   task automatic crc_pulses(input int n);
      repeat (n)
      begin
         tick(1);
         framer.crc_error = 1'b1;
         tick(1);
         framer.crc_error = 1'b0;
      end
   endtask

   // ----------
   // Scenarios
   // ----------
   task automatic t_tx();
      logic [3:0] d = 4'hB;
      logic [7:0] e = 8'h86;
      @(negedge transmit_clock_in);
      for (int i = 0; i < 4; i++)
      begin
         #1;
         tx_data_in = d[i];
         @(negedge transmit_clock_in);
         check("tx pair", {6'h00, tx_positive_pulse, tx_negative_pulse}, {6'h00, e[2*i +: 2]});
      end
      #1;
      tx_data_in = 1'b0;
   endtask

   task automatic t_status();
      rx_mode = 2'h1;
      tick(1120);
      rx_mode = 2'h0;
      framer.esf_mode = 1'b1;
      external_scan_input = 1'b1;
      crc_pulses(3);
      framer.esf_mode = 1'b0;
      crc_pulses(1);
      framer.esf_mode = 1'b1;
      send_sig(5'h00, 4'hA);
      send_sig(5'h0A, 4'h3);
      send_sig(5'h17, 4'h5);
      wait_frames(2);
      get(31);
      check("status two", w & 8'hBF, 8'h2B);
      get(4);
      check("sig ch0", w, 8'h0A);
      get(14);
      check("sig ch10", w, 8'h03);
      get(28);
      check("sig ch23", w, 8'h05);
   endtask

   task automatic t_freeze();
      framer.sync_lost = 1'b1;
      external_scan_input = 1'b0;
      crc_pulses(6);
      send_sig(5'h00, 4'h6);
      wait_frames(2);
      get(4);
      check("frozen ch0", w, 8'h0A);
      get(31);
      check("status two", w & 8'hBF, 8'h89);
   endtask

   task automatic t_d3d4();
      framer.esf_mode = 1'b0;
      send_sig(5'h00, 4'hF);
      wait_frames(2);
      get(4);
      check("d3d4 ch0", w, 8'h0C);
      framer.terminal_sync_lost = 1'b1;
      send_sig(5'h00, 4'h0);
      wait_frames(2);
      get(4);
      check("d3d4 frozen", w, 8'h0C);
   endtask

   task automatic t_debounce();
      rx_mode = 2'h2;
      framer = '0;
      framer.esf_mode = 1'b1;
      framer.debounce_enable = 1'b1;
      wait_frames(1);
      send_sig(5'h01, 4'h9);
      wait_frames(1);
      get(5);
      check("debounce early", w, 8'h00);
      wait_frames(3);
      get(5);
      check("debounce late", w, 8'h09);
      get(31);
      check("blue cleared", w & 8'h80, 8'h00);
   endtask

   initial
   begin
      tick(3);
      rst = 1'b0;
      tick(40);
      t_tx();
      t_status();
      t_freeze();
      t_d3d4();
      t_debounce();
      conclude();
   end
endmodule // tb
`default_nettype wire
